// ===== logic/power_wake_pkg.sv
// shared constants and types for the power, wake-up and port block
// assumes an 8-bit register view sitting on a 32-bit classic Wishbone bus
package power_wake_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CLKMD    = 8'h00;
    localparam logic [7:0] ADDR_INTEN    = 8'h04;
    localparam logic [7:0] ADDR_INTEN_S  = 8'h08;
    localparam logic [7:0] ADDR_INTEN_C  = 8'h0C;
    localparam logic [7:0] ADDR_MISC     = 8'h10;
    localparam logic [7:0] ADDR_PDATA    = 8'h14;
    localparam logic [7:0] ADDR_PDIR     = 8'h18;
    localparam logic [7:0] ADDR_PPULL    = 8'h1C;
    localparam logic [7:0] ADDR_PDIEN    = 8'h20;
    localparam logic [7:0] ADDR_STOP     = 8'h24;
    localparam logic [7:0] ADDR_STATUS   = 8'h28;
    // reset values and the interrupt enable write mask
    localparam logic [7:0] CLKMD_RST     = 8'hF6;
    localparam logic [7:0] INTEN_RST     = 8'h00;
    localparam logic [7:0] INTEN_MASK    = 8'h85;
    localparam logic [7:0] PORT_RST      = 8'h00;
    // clock mode, interrupt enable and misc field positions
    localparam int CLKMD_SEL_LSB = 5;
    localparam int CLKMD_HF_EN   = 4;
    localparam int CLKMD_TYPE    = 3;
    localparam int CLKMD_LF_EN   = 2;
    localparam int CLKMD_WD_EN   = 1;
    localparam int INTEN_KEEP    = 7;
    localparam int MISC_FAST     = 0;
    // stop command codes
    localparam logic [7:0] STOP_LIGHT = 8'h01;
    localparam logic [7:0] STOP_DEEP  = 8'h02;
    // wake-up counts
    localparam logic [10:0] NORMAL_WAKE_TICKS = 11'h400;
    localparam logic [10:0] FAST_WAKE_TICKS   = 11'h080;
    // clock figures
    localparam int MCLK_PERIOD_NS = 4;
    // reset causes
    typedef enum logic [1:0] {
        CAUSE_POWERUP  = 2'b00,
        CAUSE_BROWNOUT = 2'b01,
        CAUSE_EXTPIN   = 2'b10,
        CAUSE_WATCHDOG = 2'b11
    } rst_cause_t;
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_LSTOP = 2'b01,
        ST_DSTOP = 2'b10,
        ST_WAKE  = 2'b11
    } pstate_t;
endpackage : power_wake_pkg

// ===== logic/wake_if.sv
// carrier between the sequencer and its wake-up delay counter
// assumes both ends share one clock
`timescale 1ns/100ps
interface wake_if;
    logic start;
    logic fast;
    logic deep;
    logic lf_tick;
    logic sys_tick;
    logic busy;
    logic done;
    modport ctl (output start, output fast, output deep, output lf_tick, output sys_tick,
                 input busy, input done);
    modport tmr (input start, input fast, input deep, input lf_tick, input sys_tick,
                 output busy, output done);
endinterface : wake_if

// ===== logic/wake_delay.sv
// wake-up delay counter: optional oscillator settling, then ticks
// assumes ticks are one-cycle enables on the same clock
`timescale 1ns/100ps
module wake_delay
    import power_wake_pkg::*;
#(
    parameter int SETTLE_CYC = 1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    wake_if.tmr       w
);
    logic [15:0] settle_q;
    logic [10:0] cnt_q;
    logic        fast_q;

    generate
        if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad
            $error("wake_delay: settle count out of range");
        end
    endgenerate

    // fast mode counts system ticks, normal mode low-freq ticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_q <= 16'h0000;
            cnt_q    <= 11'h000;
            fast_q   <= 1'b0;
            w.busy   <= 1'b0;
            w.done   <= 1'b0;
        end else if (w.start) begin
            w.busy   <= 1'b1;
            w.done   <= 1'b0;
            fast_q   <= w.fast;
            settle_q <= (w.fast && w.deep) ? 16'(SETTLE_CYC) : 16'h0000;
            cnt_q    <= w.fast ? FAST_WAKE_TICKS : NORMAL_WAKE_TICKS;
        end else if (w.busy) begin
            if (settle_q != 16'h0000) begin
                settle_q <= settle_q - 16'h0001;
            end else if (fast_q ? w.sys_tick : w.lf_tick) begin
                if (cnt_q == 11'h001) begin
                    w.busy <= 1'b0;
                    w.done <= 1'b1;
                end
                cnt_q <= cnt_q - 11'h001;
            end
        end else begin
            w.done <= 1'b0;
        end
    end
endmodule : wake_delay

// ===== logic/low_power_wake_reset_io.sv
// power-save / power-down sequencer, reset handling and port pins
// assumes a classic Wishbone master on MCLK and asynchronous pads
`timescale 1ns/100ps
module low_power_wake_reset_io
    import power_wake_pkg::*;
#(
    parameter int         PORT_W        = 8,
    parameter int         OD_PIN        = 5,
    parameter int         LF_DIV        = 6750,
    parameter int         HF_DIV        = 16,
    parameter int         HF_SETTLE_NS  = 20000,
    parameter logic [2:0] BROWNOUT_OPT  = 3'h3
) (
    input  wire logic                 MCLK,
    input  wire logic                 RSTN,
    input  wire logic                 WB_CYC_I,
    input  wire logic                 WB_STB_I,
    input  wire logic                 WB_WE_I,
    input  wire logic [7:0]           WB_ADR_I,
    input  wire logic [3:0]           WB_SEL_I,
    input  wire logic [31:0]          WB_DAT_I,
    output logic      [31:0]          WB_DAT_O,
    output logic                      WB_ACK_O,
    input  wire logic                 BROWNOUT_DET,
    input  wire logic                 EXT_RESET_PIN_N,
    input  wire logic                 WATCHDOG_TIMEOUT,
    input  wire logic                 TIMER_WAKE,
    input  wire logic [PORT_W-1:0]    PAD_IN,
    output logic      [PORT_W-1:0]    PAD_OUT,
    output logic      [PORT_W-1:0]    PAD_OE_N,
    output logic      [PORT_W-1:0]    PAD_PULLUP_EN,
    output logic                      CPU_CLK_EN,
    output logic                      CPU_RESET_N,
    output logic                      HF_OSC_EN,
    output logic                      LF_OSC_EN,
    output logic                      PROG_MEM_EN,
    output logic                      WATCHDOG_EN,
    output logic                      RAM_RETAINED,
    output logic      [2:0]           BROWNOUT_LEVEL
);
    localparam int SETTLE_CYC = (HF_SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    generate
        if (PORT_W < 6 || PORT_W > 8 || OD_PIN >= PORT_W || LF_DIV < 2 || HF_DIV < 2
            || LF_DIV > 65535 || HF_DIV > 255) begin : g_bad
            $error("low_power_wake_reset_io: unsupported parameter values");
        end
    endgenerate

    // system clock divider mask from the clock mode selection, in high-freq ticks
    function automatic logic [6:0] hf_mask(input logic type1, input logic [2:0] sel);
        logic [6:0] m;
        m = 7'h03;
        if (!type1) begin
            m = (sel == 3'h1) ? 7'h01 : 7'h03;
        end else begin
            if (sel == 3'h0) m = 7'h0F;
            else if (sel == 3'h1) m = 7'h07;
            else if (sel == 3'h3) m = 7'h1F;
            else m = 7'h3F;
        end
        return m;
    endfunction : hf_mask

    logic [7:0]        clkmd_q, inten_q, misc_q;
    logic [PORT_W-1:0] pdata_q, pdir_q, ppull_q, pdien_q;
    logic [PORT_W-1:0] pad_s1_q, pad_s2_q, pad_prev_q;
    logic              bo_s1_q, bo_s2_q, xr_s1_q, xr_s2_q;
    logic              soft_rst_q;
    rst_cause_t        cause_q;
    pstate_t           state_q;
    logic              stop_deep_q;
    logic [15:0]       lf_cnt_q;
    logic [7:0]        hf_cnt_q;
    logic [6:0]        pre_q;
    logic [1:0]        lf_pre_q;
    logic              lf_tick, hf_tick, sys_tick;
    logic              bus_req, bus_wr, bus_rd;
    logic [7:0]        wdat, rdat;
    logic [PORT_W-1:0] toggle, drive_low;
    logic              pin_wake, cmd_light, cmd_deep;

    wake_if w ();

    wake_delay #(.SETTLE_CYC(SETTLE_CYC)) u_wake (
        .clk   (MCLK),
        .rst_n (RSTN),
        .w     (w.tmr)
    );

    // asynchronous inputs pass two flip-flops first
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            pad_s1_q   <= '0;
            pad_s2_q   <= '0;
            pad_prev_q <= '0;
            bo_s1_q    <= 1'b0;
            bo_s2_q    <= 1'b0;
            xr_s1_q    <= 1'b1;
            xr_s2_q    <= 1'b1;
        end else begin
            pad_s1_q   <= PAD_IN;
            pad_s2_q   <= pad_s1_q;
            pad_prev_q <= pad_s2_q;
            bo_s1_q    <= BROWNOUT_DET;
            bo_s2_q    <= bo_s1_q;
            xr_s1_q    <= EXT_RESET_PIN_N;
            xr_s2_q    <= xr_s1_q;
        end
    end

    // internal reset from brownout, reset pin or watchdog; cause survives it
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            soft_rst_q <= 1'b0;
            cause_q    <= CAUSE_POWERUP;
        end else begin
            soft_rst_q <= bo_s2_q || !xr_s2_q || WATCHDOG_TIMEOUT;
            if (bo_s2_q) cause_q <= CAUSE_BROWNOUT;
            else if (!xr_s2_q) cause_q <= CAUSE_EXTPIN;
            else if (WATCHDOG_TIMEOUT) cause_q <= CAUSE_WATCHDOG;
        end
    end

    // bus decode; writes are refused in power-down so state is frozen
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign bus_wr  = bus_req && WB_WE_I && WB_SEL_I[0] && state_q != ST_DSTOP;
    assign bus_rd  = bus_req && !WB_WE_I;
    assign wdat    = WB_DAT_I[7:0];
    assign cmd_light = bus_wr && WB_ADR_I == ADDR_STOP && wdat == STOP_LIGHT && state_q == ST_RUN;
    assign cmd_deep  = bus_wr && WB_ADR_I == ADDR_STOP && wdat == STOP_DEEP && state_q == ST_RUN;

    // control registers, reloaded on every reset
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            clkmd_q <= CLKMD_RST;
            inten_q <= INTEN_RST;
            misc_q  <= 8'h00;
        end else if (soft_rst_q) begin
            clkmd_q <= CLKMD_RST;
            inten_q <= INTEN_RST;
            misc_q  <= 8'h00;
        end else if (bus_wr) begin
            if (WB_ADR_I == ADDR_CLKMD) clkmd_q <= wdat;
            else if (WB_ADR_I == ADDR_INTEN) inten_q <= wdat & INTEN_MASK;
            else if (WB_ADR_I == ADDR_INTEN_S) inten_q <= inten_q | (wdat & INTEN_MASK);
            else if (WB_ADR_I == ADDR_INTEN_C) begin
                // bit 7 is kept out of the clear mask; bit-wise clears cannot drop it
                inten_q <= inten_q & ~(wdat & INTEN_MASK & 8'h7F);
            end else if (WB_ADR_I == ADDR_MISC) misc_q <= {7'h00, wdat[MISC_FAST]};
        end
    end

    // port registers
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            pdata_q <= '0;
            pdir_q  <= '0;
            ppull_q <= '0;
            pdien_q <= '0;
        end else if (soft_rst_q) begin
            pdata_q <= PORT_RST[PORT_W-1:0];
            pdir_q  <= PORT_RST[PORT_W-1:0];
            ppull_q <= PORT_RST[PORT_W-1:0];
            pdien_q <= PORT_RST[PORT_W-1:0];
        end else if (bus_wr) begin
            if (WB_ADR_I == ADDR_PDATA) pdata_q <= wdat[PORT_W-1:0];
            else if (WB_ADR_I == ADDR_PDIR) pdir_q <= wdat[PORT_W-1:0];
            else if (WB_ADR_I == ADDR_PPULL) ppull_q <= wdat[PORT_W-1:0];
            else if (WB_ADR_I == ADDR_PDIEN) pdien_q <= wdat[PORT_W-1:0];
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdat = 8'h00;
        if (WB_ADR_I == ADDR_CLKMD) rdat = clkmd_q;
        else if (WB_ADR_I == ADDR_INTEN) rdat = inten_q;
        else if (WB_ADR_I == ADDR_MISC) rdat = misc_q;
        else if (WB_ADR_I == ADDR_PDATA) begin
            rdat = 8'((pdir_q & pdata_q) | (~pdir_q & pad_s2_q));
        end else if (WB_ADR_I == ADDR_PDIR) rdat = 8'(pdir_q);
        else if (WB_ADR_I == ADDR_PPULL) rdat = 8'(ppull_q);
        else if (WB_ADR_I == ADDR_PDIEN) rdat = 8'(pdien_q);
        else if (WB_ADR_I == ADDR_STATUS) rdat = {2'h0, RAM_RETAINED, cause_q, w.busy, state_q};
    end

    // single-cycle acknowledge, one wait state; ack drops the cycle after
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            if (bus_rd) WB_DAT_O <= {24'h00_0000, rdat};
        end
    end

    // oscillator stand-ins; both stop dead in power-down
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            lf_cnt_q <= 16'h0000;
            hf_cnt_q <= 8'h00;
            pre_q    <= 7'h00;
            lf_pre_q <= 2'h0;
        end else begin
            if (state_q == ST_DSTOP || !clkmd_q[CLKMD_LF_EN]) lf_cnt_q <= 16'h0000;
            else if (lf_tick) lf_cnt_q <= 16'h0000;
            else lf_cnt_q <= lf_cnt_q + 16'h0001;
            if (state_q == ST_DSTOP || !clkmd_q[CLKMD_HF_EN]) hf_cnt_q <= 8'h00;
            else if (hf_tick) hf_cnt_q <= 8'h00;
            else hf_cnt_q <= hf_cnt_q + 8'h01;
            if (hf_tick) pre_q <= pre_q + 7'h01;
            if (lf_tick) lf_pre_q <= lf_pre_q + 2'h1;
        end
    end

    assign lf_tick = state_q != ST_DSTOP && clkmd_q[CLKMD_LF_EN] && lf_cnt_q == 16'(LF_DIV - 1);
    assign hf_tick = state_q != ST_DSTOP && clkmd_q[CLKMD_HF_EN] && hf_cnt_q == 8'(HF_DIV - 1);

    // system clock enable: low-freq /1 or /4, else high-freq divided
    always_comb begin
        if (!clkmd_q[CLKMD_TYPE] && clkmd_q[7:5] == 3'h7) begin
            sys_tick = lf_tick;
        end else if (!clkmd_q[CLKMD_TYPE] && clkmd_q[7:5] == 3'h6) begin
            sys_tick = lf_tick && lf_pre_q == 2'h0;
        end else begin
            sys_tick = hf_tick && (pre_q & hf_mask(clkmd_q[CLKMD_TYPE], clkmd_q[7:5])) == 7'h00;
        end
    end

    // wake sources: toggles on enabled input pins, timer in light stop only
    assign toggle   = (pad_s2_q ^ pad_prev_q) & ~pdir_q & pdien_q;
    assign pin_wake = |toggle;

    assign w.start    = (state_q == ST_LSTOP && (pin_wake || TIMER_WAKE))
                     || (state_q == ST_DSTOP && pin_wake);
    assign w.fast     = misc_q[MISC_FAST];
    assign w.deep     = state_q == ST_DSTOP;
    assign w.lf_tick  = lf_tick;
    assign w.sys_tick = sys_tick;

    // power state machine; wake resumes the halted CPU, never vectors
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q     <= ST_RUN;
            stop_deep_q <= 1'b0;
        end else if (soft_rst_q) begin
            state_q     <= ST_RUN;
            stop_deep_q <= 1'b0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (cmd_deep) begin
                        state_q     <= ST_DSTOP;
                        stop_deep_q <= 1'b1;
                    end else if (cmd_light) begin
                        state_q     <= ST_LSTOP;
                        stop_deep_q <= 1'b0;
                    end
                end
                ST_LSTOP: begin
                    if (w.start) state_q <= ST_WAKE;
                end
                ST_DSTOP: begin
                    if (w.start) state_q <= ST_WAKE;
                end
                ST_WAKE: begin
                    if (w.done) state_q <= ST_RUN;
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // pad drivers; open-drain pin has no high side
    assign drive_low = pdir_q & ~pdata_q;

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            PAD_OUT       <= '0;
            PAD_OE_N      <= '1;
            PAD_PULLUP_EN <= '0;
        end else begin
            for (int i = 0; i < PORT_W; i++) begin
                if (i == OD_PIN) begin
                    PAD_OUT[i]  <= 1'b0;
                    PAD_OE_N[i] <= !drive_low[i];
                end else begin
                    PAD_OUT[i]  <= pdata_q[i];
                    PAD_OE_N[i] <= !pdir_q[i];
                end
                PAD_PULLUP_EN[i] <= ppull_q[i] && !drive_low[i];
            end
        end
    end

    // clock, memory and oscillator controls
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            CPU_CLK_EN     <= 1'b0;
            CPU_RESET_N    <= 1'b0;
            HF_OSC_EN      <= 1'b0;
            LF_OSC_EN      <= 1'b0;
            PROG_MEM_EN    <= 1'b0;
            WATCHDOG_EN    <= 1'b0;
            RAM_RETAINED   <= 1'b0;
            BROWNOUT_LEVEL <= 3'h0;
        end else begin
            CPU_CLK_EN     <= state_q == ST_RUN;
            CPU_RESET_N    <= !soft_rst_q;
            HF_OSC_EN      <= state_q != ST_DSTOP && clkmd_q[CLKMD_HF_EN];
            LF_OSC_EN      <= state_q != ST_DSTOP && clkmd_q[CLKMD_LF_EN];
            PROG_MEM_EN    <= state_q == ST_RUN || state_q == ST_WAKE;
            WATCHDOG_EN    <= clkmd_q[CLKMD_WD_EN] && clkmd_q[CLKMD_LF_EN];
            RAM_RETAINED   <= cause_q == CAUSE_EXTPIN || cause_q == CAUSE_WATCHDOG;
            BROWNOUT_LEVEL <= BROWNOUT_OPT;
        end
    end
endmodule : low_power_wake_reset_io

// ===== bench/pad_model.sv
// pad model: resolves each pin from its driver, pull-up and the outside world
// assumes the bench drives ext for every pin at all times
`timescale 1ns/100ps
module pad_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] oe_n,
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] pu,
    input  wire logic [W-1:0] ext,
    output logic      [W-1:0] pad
);
    // a driven pin shows its driver, else the pull-up wins over the outside
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad[i] = !oe_n[i] ? out[i] : (pu[i] ? 1'b1 : ext[i]);
        end
    end
endmodule : pad_model

// ===== bench/wake_io_properties.sv
// checker for pins, stop states and reset causes of the power block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/100ps
module wake_io_properties #(
    parameter int         PORT_W       = 8,
    parameter int         OD_PIN       = 5,
    parameter logic [2:0] BROWNOUT_OPT = 3'h3
) (
    input wire logic              MCLK,
    input wire logic              RSTN,
    input wire logic [PORT_W-1:0] PAD_IN,
    input wire logic [PORT_W-1:0] PAD_OUT,
    input wire logic [PORT_W-1:0] PAD_OE_N,
    input wire logic [PORT_W-1:0] PAD_PULLUP_EN,
    input wire logic              CPU_CLK_EN,
    input wire logic              CPU_RESET_N,
    input wire logic              HF_OSC_EN,
    input wire logic              LF_OSC_EN,
    input wire logic              PROG_MEM_EN,
    input wire logic              RAM_RETAINED,
    input wire logic [2:0]        BROWNOUT_LEVEL,
    input wire logic              TIMER_WAKE,
    input wire logic              WATCHDOG_TIMEOUT,
    input wire logic              BROWNOUT_DET
);
    logic [8:0] wake_q;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // cycles spent waking; saturates since only a lower bound matters
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            wake_q <= 9'h000;
        end else if (CPU_CLK_EN || !PROG_MEM_EN) begin
            wake_q <= 9'h000;
        end else if (wake_q != 9'h1FF) begin
            wake_q <= wake_q + 9'h001;
        end
    end
    deep_osc_off_a: assert property (!HF_OSC_EN && !LF_OSC_EN |-> !PROG_MEM_EN && !CPU_CLK_EN)
        else $error("oscillators off while running");
    pullup_low_a: assert property ((~PAD_OE_N & ~PAD_OUT & PAD_PULLUP_EN) == '0)
        else $error("pull-up on a pin driven low");
    od_no_high_a: assert property (PAD_OUT[OD_PIN] == 1'b0)
        else $error("open-drain pin driven high");
    deep_timer_a: assert property (($stable(PAD_IN) && !LF_OSC_EN && !HF_OSC_EN)[*4] ##0 TIMER_WAKE |=> !PROG_MEM_EN)
        else $error("timer woke power-down");
    wake_len_a: assert property ($rose(CPU_CLK_EN) && $past(PROG_MEM_EN) |-> wake_q >= 9'h080 && CPU_RESET_N)
        else $error("wake released early or with reset");
    wdog_reset_a: assert property ($rose(WATCHDOG_TIMEOUT) |-> ##[1:4] !CPU_RESET_N)
        else $error("watchdog gave no cpu reset");
    ram_keep_a: assert property ($rose(WATCHDOG_TIMEOUT) |-> ##[2:6] RAM_RETAINED)
        else $error("memory not kept after watchdog");
    ram_lost_a: assert property ($rose(BROWNOUT_DET) |-> ##[2:8] !RAM_RETAINED)
        else $error("memory kept after brownout");
    bo_level_a: assert property ($past(RSTN) |-> BROWNOUT_LEVEL == BROWNOUT_OPT)
        else $error("brownout level not the build option");
endmodule : wake_io_properties

// ===== bench/tb_top.sv
// bench: register bus, port pins, stop and wake timing, reset causes
// assumes the package, design, pad model and checker are compiled first
`timescale 1ns/100ps
module tb_top;
    import power_wake_pkg::*;
    localparam int LF = 4;
    logic        mclk, rst_n, cyc, we, ack, tmr_w, wdog, bo, ext_n;
    logic        clk_en, hf, lf, pm, ram, rst_cpu, wd;
    logic [7:0]  adr, ext, pad, oe_n, pout, pu, d;
    logic [31:0] dat, rdat;
    logic [7:0]  exp_q[$];
    int          errors, compares;
    low_power_wake_reset_io #(.LF_DIV(LF), .HF_DIV(2), .HF_SETTLE_NS(40)) dut (
        .MCLK(mclk), .RSTN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .BROWNOUT_DET(bo),
        .EXT_RESET_PIN_N(ext_n), .WATCHDOG_TIMEOUT(wdog), .TIMER_WAKE(tmr_w), .PAD_IN(pad),
        .PAD_OUT(pout), .PAD_OE_N(oe_n), .PAD_PULLUP_EN(pu), .CPU_CLK_EN(clk_en), .CPU_RESET_N(rst_cpu),
        .HF_OSC_EN(hf), .LF_OSC_EN(lf), .PROG_MEM_EN(pm), .WATCHDOG_EN(wd), .RAM_RETAINED(ram),
        .BROWNOUT_LEVEL());
    pad_model #(.W(8)) pads (.oe_n(oe_n), .out(pout), .pu(pu), .ext(ext), .pad(pad));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one classic cycle; request held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        int k;
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h000000, v};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        // a slave that never answers ends the run as a failure
        if (k >= 20) begin
            errors++;
            conclude();
        end
        cyc <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus(1'b1, a, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd
    // enter a stop state, wake by timer or pin, time the wake
    task automatic nap(input logic [7:0] code, input bit tmr, input int lo);
        int n;
        wr(ADDR_STOP, code);
        repeat (4) @(posedge mclk);
        check(hf & lf, code == STOP_LIGHT);
        check(pm | clk_en, 1'b0);
        if (tmr || code == STOP_DEEP) begin
            tmr_w <= 1'b1;
            @(posedge mclk);
            tmr_w <= 1'b0;
        end
        if (!tmr) begin
            repeat (20) @(posedge mclk);
            check(pm, 1'b0);
            ext[7] <= ~ext[7];
        end
        n = 0;
        while (clk_en !== 1'b1 && n < 6000) begin
            @(posedge mclk);
            n++;
        end
        check(n >= lo - 8 && n <= lo + 12, 1'b1);
        check(rst_cpu, 1'b1);
        $display("test stop %h done", code);
    endtask : nap
    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // read data checked against the oldest note when ack shows
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            check(rdat[7:0], exp_q.pop_front());
        end
    end
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // hang guard, well past the longest wake
    initial begin
        #100000;
        errors++;
        conclude();
    end
    initial begin
        {rst_n, cyc, we, tmr_w, wdog, bo, adr, dat, ext} = '0;
        ext_n = 1'b1;
        void'($urandom(79422));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(ADDR_CLKMD, CLKMD_RST);
        rd(8'h3C, 8'h00);
        wr(ADDR_INTEN_S, 8'h80);
        wr(ADDR_INTEN_S, 8'h05);
        wr(ADDR_INTEN_C, 8'h85);
        rd(ADDR_INTEN, 8'h80);
        check(wd, 1'b1);
        $display("test defaults done");
        d = 8'($urandom);
        ext <= 8'($urandom);
        wr(ADDR_PDIR, 8'h2F);
        wr(ADDR_PPULL, 8'h3C);
        wr(ADDR_PDATA, d);
        repeat (4) @(posedge mclk);
        check(oe_n, ~8'h2F | (8'h20 & d));
        check(pu, 8'h3C & ~(8'h2F & ~d));
        check(pout, d & 8'hDF);
        rd(ADDR_PDATA, (8'h2F & d) | (~8'h2F & (8'h3C | ext)));
        $display("test port done");
        wr(ADDR_PDIEN, 8'h81);
        rd(ADDR_INTEN, 8'h80);
        wr(ADDR_CLKMD, 8'hF4);
        @(posedge mclk);
        check(wd, 1'b0);
        nap(STOP_LIGHT, 1'b1, 1024 * LF);
        wr(ADDR_MISC, 8'h01);
        nap(STOP_LIGHT, 1'b0, 128 * LF);
        nap(STOP_DEEP, 1'b0, 128 * LF + 10);
        // high-freq /2 system clock; with HF_DIV 2 a tick is also 4 MCLK
        wr(ADDR_CLKMD, 8'h34);
        nap(STOP_LIGHT, 1'b0, 128 * 4);
        rd(ADDR_PDIR, 8'h2F);
        // watchdog first, then brownout, so that memory loss follows a kept state
        for (int i = 1; i < 4; i++) begin
            int c;
            c = (i + 1) % 3 + 1;
            bo <= (c == 1);
            ext_n <= (c != 2);
            wdog <= (c == 3);
            repeat (3) @(posedge mclk);
            {bo, wdog} <= 2'b00;
            ext_n <= 1'b1;
            repeat (10) @(posedge mclk);
            check(ram, c > 1);
            rd(ADDR_STATUS, {2'b00, c > 1, 2'(c), 3'b000});
        end
        check(rst_cpu, 1'b1);
        rd(ADDR_CLKMD, CLKMD_RST);
        rd(ADDR_MISC, 8'h00);
        $display("test resets done");
        repeat (5) @(posedge mclk);
        conclude();
    end
endmodule : tb_top
bind low_power_wake_reset_io wake_io_properties #(.PORT_W(PORT_W), .OD_PIN(OD_PIN), .BROWNOUT_OPT(BROWNOUT_OPT)) chk (
    .MCLK(MCLK), .RSTN(RSTN), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE_N(PAD_OE_N),
    .PAD_PULLUP_EN(PAD_PULLUP_EN), .CPU_CLK_EN(CPU_CLK_EN), .CPU_RESET_N(CPU_RESET_N), .HF_OSC_EN(HF_OSC_EN),
    .LF_OSC_EN(LF_OSC_EN), .PROG_MEM_EN(PROG_MEM_EN), .RAM_RETAINED(RAM_RETAINED), .BROWNOUT_LEVEL(BROWNOUT_LEVEL),
    .TIMER_WAKE(TIMER_WAKE), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .BROWNOUT_DET(BROWNOUT_DET));
